// *** shared/vls_pkg.sv ***
// Constants and types shared by the vector left-shift datapath
package vls_pkg;

  // Operand and lane widths
  localparam int VLS_DATA_W     = 32;
  localparam int VLS_HALF_W     = 16;
  localparam int VLS_BYTE_W     = 8;
  localparam int VLS_HALF_LANES = 2;
  localparam int VLS_BYTE_LANES = 4;

  // Shift count field widths
  localparam int VLS_HALF_CNT_W = 4;
  localparam int VLS_BYTE_CNT_W = 3;
  localparam int VLS_WORD_CNT_W = 5;

  // Overflow flag position in the DSP control register
  localparam int VLS_OUFLAG_BIT = 22;
  localparam logic [31:0] VLS_OUFLAG_MASK = 32'h0040_0000;

  // Reset values
  localparam logic [31:0] VLS_CTL_RST    = 32'h0000_0000;
  localparam logic [31:0] VLS_RESULT_RST = 32'h0000_0000;

  // Saturation limits
  localparam logic [15:0] VLS_HALF_POS = 16'h7FFF;
  localparam logic [15:0] VLS_HALF_NEG = 16'h8000;
  localparam logic [31:0] VLS_WORD_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] VLS_WORD_NEG = 32'h8000_0000;

  // Operation select, one-hot
  typedef enum logic [4:0] {
    VLS_OP_HP     = 5'h01,  // var_halfword_pair_shift_left
    VLS_OP_HP_SAT = 5'h02,  // var_halfword_pair_shift_left_sat
    VLS_OP_QB     = 5'h04,  // var_quad_byte_shift_left
    VLS_OP_W_SAT  = 5'h08,  // var_word_shift_left_sat
    VLS_OP_IMM_W  = 5'h10   // imm_word_shift_left_sat
  } vls_op_t;

endpackage

// *** rtl/vls_shift_unit.sv ***
`timescale 1ns/10ps
module vls_shift_unit
  import vls_pkg::*;
#(
  parameter int DATA_W = VLS_DATA_W
) (
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_sys_rst,
  // Issue from the pipeline
  input  wire logic              i_issue,
  input  wire vls_op_t           i_op,
  input  wire logic [31:0]       i_count_reg,
  input  wire logic [31:0]       i_source,
  input  wire logic [4:0]        i_imm,
  // DSP resource state
  input  wire logic              i_dsp_present,
  input  wire logic              i_dsp_enabled,
  // Control register write port
  input  wire logic              i_ctl_wr,
  input  wire logic [31:0]       i_ctl_wdata,
  // Results
  output logic [31:0]            o_result,
  output logic                   o_result_valid,
  output logic                   o_overflow,
  output logic                   o_exc_reserved,
  output logic                   o_exc_dsp_disabled,
  output logic [31:0]            o_dsp_control
);

  // Only the documented word width is served
  if (DATA_W != 32) begin : g_width_check
    $error("vls_shift_unit serves a 32-bit datapath only");
  end

  // Operation decode
  wire logic is_hp     = (i_op == VLS_OP_HP);
  wire logic is_hp_sat = (i_op == VLS_OP_HP_SAT);
  wire logic is_qb     = (i_op == VLS_OP_QB);
  wire logic is_w_sat  = (i_op == VLS_OP_W_SAT);
  wire logic is_imm_w  = (i_op == VLS_OP_IMM_W);
  wire logic is_half   = is_hp | is_hp_sat;
  wire logic is_word   = is_w_sat | is_imm_w;
  wire logic op_known  = is_half | is_qb | is_word;

  // Access check ahead of execution
  wire logic exec_ok  = i_issue & i_dsp_present & i_dsp_enabled & op_known;
  wire logic exc_ri   = i_issue & (~i_dsp_present | ~op_known);
  wire logic exc_dd   = i_issue & i_dsp_present & op_known & ~i_dsp_enabled;

  // Shift counts, unsigned, upper bits ignored
  wire logic [3:0] half_cnt = i_count_reg[VLS_HALF_CNT_W-1:0];
  wire logic [2:0] byte_cnt = i_count_reg[VLS_BYTE_CNT_W-1:0];
  wire logic [4:0] word_cnt = is_imm_w ? i_imm
                                       : i_count_reg[VLS_WORD_CNT_W-1:0];

  logic [31:0] half_res;
  logic [1:0]  half_ovf;
  logic [31:0] byte_res;
  logic [3:0]  byte_ovf;

  // Halfword lanes: probe keeps sign plus shifted-out bits
  for (genvar g = 0; g < VLS_HALF_LANES; g++) begin : g_half
    wire logic [15:0] lane_in  = i_source[g*VLS_HALF_W +: VLS_HALF_W];
    wire logic [15:0] lane_sh  = lane_in << half_cnt;
    wire logic [3:0]  probe_sh = 4'hF - half_cnt;
    wire logic [15:0] probe    = 16'($signed(lane_in) >>> probe_sh);
    wire logic [15:0] lane_lim = lane_in[15] ? VLS_HALF_NEG : VLS_HALF_POS;
    assign half_ovf[g] = (probe != 16'h0000) && (probe != 16'hFFFF);
    assign half_res[g*VLS_HALF_W +: VLS_HALF_W] =
      (is_hp_sat && half_ovf[g]) ? lane_lim : lane_sh;
  end

  // Byte lanes: shift only, no clamping
  for (genvar g = 0; g < VLS_BYTE_LANES; g++) begin : g_byte
    wire logic [7:0] lane_in  = i_source[g*VLS_BYTE_W +: VLS_BYTE_W];
    wire logic [2:0] probe_sh = 3'h7 - byte_cnt;
    wire logic [7:0] probe    = 8'($signed(lane_in) >>> probe_sh);
    assign byte_ovf[g] = (probe != 8'h00) && (probe != 8'hFF);
    assign byte_res[g*VLS_BYTE_W +: VLS_BYTE_W] = lane_in << byte_cnt;
  end

  // Whole word lane
  wire logic [31:0] word_sh    = i_source << word_cnt;
  wire logic [4:0]  word_psh   = 5'h1F - word_cnt;
  wire logic [31:0] word_probe = 32'($signed(i_source) >>> word_psh);
  wire logic        word_ovf   = (word_probe != 32'h0000_0000)
                              && (word_probe != 32'hFFFF_FFFF);
  wire logic [31:0] word_lim   = i_source[31] ? VLS_WORD_NEG : VLS_WORD_POS;
  wire logic [31:0] word_res   = word_ovf ? word_lim : word_sh;

  // Result and overflow selection
  wire logic [31:0] result_sel = is_half ? half_res
                               : is_qb   ? byte_res
                               : word_res;
  wire logic        ovf_sel    = is_half ? (|half_ovf)
                               : is_qb   ? (|byte_ovf)
                               : (is_word & word_ovf);

  // Control register: write port, then sticky set that wins
  logic [31:0] ctl_r;
  logic [31:0] ctl_nxt;
  wire logic [31:0] ctl_base = i_ctl_wr ? i_ctl_wdata : ctl_r;
  wire logic        flag_set = exec_ok & ovf_sel;
  assign ctl_nxt = flag_set ? (ctl_base | VLS_OUFLAG_MASK) : ctl_base;

  // Output registers
  logic [31:0] result_r;
  logic        valid_r;
  logic        ovf_r;
  logic        exc_ri_r;
  logic        exc_dd_r;

  // One-cycle pipeline stage
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      result_r <= VLS_RESULT_RST;
      valid_r  <= 1'b0;
      ovf_r    <= 1'b0;
      exc_ri_r <= 1'b0;
      exc_dd_r <= 1'b0;
      ctl_r    <= VLS_CTL_RST;
    end else begin
      result_r <= exec_ok ? result_sel : result_r;
      valid_r  <= exec_ok;
      ovf_r    <= flag_set;
      exc_ri_r <= exc_ri;
      exc_dd_r <= exc_dd;
      ctl_r    <= ctl_nxt;
    end
  end

  // Ports straight from flops
  assign o_result           = result_r;
  assign o_result_valid     = valid_r;
  assign o_overflow         = ovf_r;
  assign o_exc_reserved     = exc_ri_r;
  assign o_exc_dsp_disabled = exc_dd_r;
  assign o_dsp_control      = ctl_r;

  // Checks on the datapath and the flag
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  wire logic go_hp  = exec_ok & is_hp;
  wire logic go_hps = exec_ok & is_hp_sat;
  wire logic go_qb  = exec_ok & is_qb;
  wire logic go_w   = exec_ok & is_w_sat;
  wire logic go_imm = exec_ok & is_imm_w;

  property p_half_cnt;
    go_hp |=> o_result_valid
          && o_result[15:0] == 16'($past(i_source[15:0]) << $past(i_count_reg[3:0]));
  endproperty
  a_half_cnt: assert property (p_half_cnt) else $error("halfword count misused");

  property p_half_sat;
    go_hps && half_ovf[1] |=>
      o_result[31:16] == ($past(i_source[31]) ? 16'h8000 : 16'h7FFF);
  endproperty
  a_half_sat: assert property (p_half_sat) else $error("halfword clamp wrong");

  property p_half_lanes;
    go_hp |=> o_result[31:16] == 16'($past(i_source[31:16]) << $past(i_count_reg[3:0]));
  endproperty
  a_half_lanes: assert property (p_half_lanes) else $error("upper halfword wrong");

  property p_byte_cnt;
    go_qb |=> o_result[7:0] == 8'($past(i_source[7:0]) << $past(i_count_reg[2:0]));
  endproperty
  a_byte_cnt: assert property (p_byte_cnt) else $error("byte count misused");

  property p_byte_nosat;
    go_qb |=> o_result[31:24] == 8'($past(i_source[31:24]) << $past(i_count_reg[2:0]));
  endproperty
  a_byte_nosat: assert property (p_byte_nosat) else $error("byte lane clamped");

  property p_word_shift;
    go_w && !word_ovf |=>
      o_result == 32'($past(i_source) << $past(i_count_reg[4:0]));
  endproperty
  a_word_shift: assert property (p_word_shift) else $error("word shift wrong");

  property p_word_sat;
    (go_w || go_imm) && word_ovf |=>
      o_result == ($past(i_source[31]) ? 32'h8000_0000 : 32'h7FFF_FFFF) && o_overflow;
  endproperty
  a_word_sat: assert property (p_word_sat) else $error("word clamp wrong");

  property p_imm_cnt;
    go_imm && i_imm == 5'h00 |=> o_result == $past(i_source);
  endproperty
  a_imm_cnt: assert property (p_imm_cnt) else $error("immediate count misused");

  property p_word_lim;
    go_w && i_source[31] && !i_source[30] && i_count_reg[4:0] != 5'h00
      |=> o_result == 32'h8000_0000;
  endproperty
  a_word_lim: assert property (p_word_lim) else $error("negative limit wrong");

  property p_ovf_def;
    (go_w || go_imm) && word_cnt != 5'h00 && i_source[31] != i_source[30]
      |=> o_overflow;
  endproperty
  a_ovf_def: assert property (p_ovf_def) else $error("overflow missed");

  property p_flag_set;
    exec_ok && ovf_sel |=> o_dsp_control[VLS_OUFLAG_BIT] && o_overflow;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_access;
    i_issue && op_known && !i_dsp_present |=> o_exc_reserved && !o_result_valid;
  endproperty
  a_access: assert property (p_access) else $error("access check skipped");

  property p_no_data_exc;
    exec_ok |=> !o_exc_reserved && !o_exc_dsp_disabled && o_result_valid;
  endproperty
  a_no_data_exc: assert property (p_no_data_exc) else $error("data exception");

  property p_zero_cnt;
    go_hps && i_count_reg[3:0] == 4'h0 |=> o_result == $past(i_source) && !o_overflow;
  endproperty
  a_zero_cnt: assert property (p_zero_cnt) else $error("zero count altered");

  property p_sticky;
    o_dsp_control[VLS_OUFLAG_BIT] && !i_ctl_wr |=> o_dsp_control[VLS_OUFLAG_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_others_kept;
    !i_ctl_wr |=> (o_dsp_control & ~VLS_OUFLAG_MASK) == ($past(o_dsp_control) & ~VLS_OUFLAG_MASK);
  endproperty
  a_others_kept: assert property (p_others_kept) else $error("control bits changed");

  property p_disabled;
    i_issue && i_dsp_present && op_known && !i_dsp_enabled
      |=> o_exc_dsp_disabled && !o_exc_reserved && !o_result_valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled check skipped");

  property p_unknown_op;
    i_issue && !op_known |=> o_exc_reserved && !o_result_valid && !o_overflow;
  endproperty
  a_unknown_op: assert property (p_unknown_op) else $error("unknown op executed");

  property p_refused_flag;
    i_issue && !exec_ok && !i_ctl_wr |=> o_dsp_control == $past(o_dsp_control);
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("flag touched");

  property p_qb_zero;
    go_qb && i_count_reg[2:0] == 3'h0 |=> o_result == $past(i_source) && !o_overflow;
  endproperty
  a_qb_zero: assert property (p_qb_zero) else $error("zero byte count altered");

  property p_word_zero;
    go_w && i_count_reg[4:0] == 5'h00 |=> o_result == $past(i_source) && !o_overflow;
  endproperty
  a_word_zero: assert property (p_word_zero) else $error("zero word count altered");

  property p_set_wins;
    flag_set && i_ctl_wr |=> o_dsp_control == ($past(i_ctl_wdata) | VLS_OUFLAG_MASK);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("write cleared flag");

  property p_ctl_write;
    i_ctl_wr && !flag_set |=> o_dsp_control == $past(i_ctl_wdata);
  endproperty
  a_ctl_write: assert property (p_ctl_write) else $error("control write lost");

  property p_imm_shift;
    go_imm && !word_ovf |=> o_result == 32'($past(i_source) << $past(i_imm));
  endproperty
  a_imm_shift: assert property (p_imm_shift) else $error("immediate shift wrong");

  property p_hp_flag;
    go_hp && (|half_ovf) |=> o_overflow && o_dsp_control[VLS_OUFLAG_BIT];
  endproperty
  a_hp_flag: assert property (p_hp_flag) else $error("halfword overflow unflagged");

  property p_quiet;
    !i_issue |=> !o_result_valid && !o_overflow && !o_exc_reserved && !o_exc_dsp_disabled;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse without issue");

  // Main scenarios
  c_half_sat:  cover property (go_hps && |half_ovf);
  c_byte_ovf:  cover property (go_qb && |byte_ovf);
  c_word_sat:  cover property (go_w && word_ovf);
  c_set_clear: cover property (flag_set && i_ctl_wr);
  c_disabled:  cover property (exc_dd);

endmodule

// *** test/vls_pipe_model.sv ***
`timescale 1ns/10ps
// Register file read ports feeding the count and source operands
module vls_pipe_model (
  // Operand values chosen by the bench
  input  wire logic        i_issue,
  input  wire logic [31:0] i_count_val,
  input  wire logic [31:0] i_source_val,
  // Read ports toward the shift unit
  output logic [31:0]      o_count_reg,
  output logic [31:0]      o_source
);
  // Outside an issue the ports show the inverse, so stale operands never match
  assign o_count_reg = i_issue ? i_count_val : ~i_count_val;
  assign o_source    = i_issue ? i_source_val : ~i_source_val;
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import vls_pkg::*;
  logic        i_clock, i_sys_rst, i_issue, i_dsp_present, i_dsp_enabled, i_ctl_wr;
  vls_op_t     i_op;
  logic [31:0] i_count_reg, i_source, i_ctl_wdata, cnt_v, src_v, o_result, o_dsp_control;
  logic [4:0]  i_imm;
  logic        o_result_valid, o_overflow, o_exc_reserved, o_exc_dsp_disabled;
  logic [31:0] ctl_exp, res_exp;
  bit          ov_exp;
  int          fails, check_count;
  vls_op_t     ops[5] = '{VLS_OP_HP, VLS_OP_HP_SAT, VLS_OP_QB, VLS_OP_W_SAT, VLS_OP_IMM_W};

  vls_pipe_model u_pipe (.i_issue(i_issue), .i_count_val(cnt_v), .i_source_val(src_v),
                         .o_count_reg(i_count_reg), .o_source(i_source));
  vls_shift_unit u_dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_issue(i_issue),
    .i_op(i_op), .i_count_reg(i_count_reg), .i_source(i_source), .i_imm(i_imm),
    .i_dsp_present(i_dsp_present), .i_dsp_enabled(i_dsp_enabled), .i_ctl_wr(i_ctl_wr),
    .i_ctl_wdata(i_ctl_wdata), .o_result(o_result), .o_result_valid(o_result_valid),
    .o_overflow(o_overflow), .o_exc_reserved(o_exc_reserved),
    .o_exc_dsp_disabled(o_exc_dsp_disabled), .o_dsp_control(o_dsp_control));

  // Core clock, 100 ns period
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  // One lane of width w shifted by s; overflow when sign and lost bits differ
  function automatic logic [31:0] lane(logic [31:0] a, int w, int s, bit sat, output bit ov);
    logic [31:0] m;
    m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
    ov = 1'b0;
    for (int i = w - 1 - s; i < w; i++) if (a[i] !== a[w-1]) ov = 1'b1;
    lane = (a << s) & m;
    if (ov && sat) lane = a[w-1] ? (32'h1 << (w - 1)) : (m >> 1);
  endfunction

  // Whole-op expectation built lane by lane
  function automatic logic [31:0] expect_op(vls_op_t op, logic [31:0] c, logic [31:0] a,
                                            logic [4:0] imm, output bit ov);
    bit          o;
    int          w, s;
    logic [31:0] r;
    ov = 1'b0;
    w = (op == VLS_OP_QB) ? 8 : (op inside {VLS_OP_HP, VLS_OP_HP_SAT}) ? 16 : 32;
    s = (op == VLS_OP_IMM_W) ? int'(imm) : int'(c) & (w - 1);
    expect_op = 32'h0;
    for (int k = 0; k < 32; k += w) begin
      r = lane(a >> k, w, s, op inside {VLS_OP_HP_SAT, VLS_OP_W_SAT, VLS_OP_IMM_W}, o);
      expect_op |= r << k;
      ov |= o;
    end
  endfunction

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Offers one op at a falling edge, checks its answer one cycle later
  task automatic run_op(vls_op_t op, logic [31:0] c, logic [31:0] a, logic [4:0] imm,
                        bit wr, logic [31:0] wd);
    i_issue = 1'b1;
    i_op = op;
    cnt_v = c;
    src_v = a;
    i_imm = imm;
    i_ctl_wr = wr;
    i_ctl_wdata = wd;
    res_exp = expect_op(op, c, a, imm, ov_exp);
    if (wr) ctl_exp = wd;
    if (ov_exp) ctl_exp[VLS_OUFLAG_BIT] = 1'b1;
    @(negedge i_clock);
    chk({31'h0, o_result_valid}, 32'h1, "valid");
    chk(o_result, res_exp, "result");
    chk({31'h0, o_overflow}, {31'h0, ov_exp}, "overflow");
    chk(o_dsp_control, ctl_exp, "control");
    chk({30'h0, o_exc_reserved, o_exc_dsp_disabled}, 32'h0, "exception");
  endtask

  // Offers an op that must be refused: no result, flag untouched
  task automatic refuse(vls_op_t op, bit pres, bit en, bit rsv);
    i_issue = 1'b1;
    i_op = op;
    i_ctl_wr = 1'b0;
    i_dsp_present = pres;
    i_dsp_enabled = en;
    src_v = 32'h40000000;
    cnt_v = 32'h1;
    @(negedge i_clock);
    chk({30'h0, o_exc_reserved, o_exc_dsp_disabled}, {30'h0, rsv, !rsv}, "refusal");
    chk({31'h0, o_result_valid | o_overflow}, 32'h0, "refused result");
    chk(o_dsp_control, ctl_exp, "refused flag");
    i_dsp_present = 1'b1;
    i_dsp_enabled = 1'b1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_issue = 1'b0;
    i_op = VLS_OP_HP;
    cnt_v = 32'h0;
    src_v = 32'h0;
    i_imm = 5'h0;
    i_dsp_present = 1'b1;
    i_dsp_enabled = 1'b1;
    i_ctl_wr = 1'b0;
    i_ctl_wdata = 32'h0;
    void'($urandom(32'h0C2366B5));
    repeat (16) @(posedge i_clock);
    @(negedge i_clock);
    i_sys_rst = 1'b0;
    ctl_exp = VLS_CTL_RST;
    @(negedge i_clock);
    chk(o_dsp_control, VLS_CTL_RST, "reset control");
    chk(o_result, VLS_RESULT_RST, "reset result");
    $display("test reset done");
    run_op(VLS_OP_W_SAT, 32'h1, 32'h40000000, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_HP, 32'hFFFFFFF0, 32'h80017FFF, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_HP_SAT, 32'hFFFFFFF1, 32'h80014000, 5'h00, 1'b1, 32'hA5A5A5A5);
    run_op(VLS_OP_QB, 32'hFFFFFFF8, 32'h807F01FF, 5'h00, 1'b1, 32'h0);
    run_op(VLS_OP_QB, 32'h7, 32'h01FF8003, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_IMM_W, 32'h0, 32'hFFFFFFFF, 5'h1F, 1'b0, 32'h0);
    run_op(VLS_OP_IMM_W, 32'h1F, 32'h80000000, 5'h01, 1'b0, 32'h0);
    run_op(VLS_OP_W_SAT, 32'hFFFFFFE0, 32'h12345678, 5'h1F, 1'b0, 32'h0);
    run_op(VLS_OP_HP_SAT, 32'h10, 32'h8000FFFF, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_W_SAT, 32'h21, 32'h80000001, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_IMM_W, 32'h3, 32'hC0000000, 5'h00, 1'b0, 32'h0);
    run_op(VLS_OP_HP, 32'h2, 32'h20004000, 5'h00, 1'b0, 32'h0);
    $display("test corners done");
    refuse(VLS_OP_HP, 1'b0, 1'b1, 1'b1);
    refuse(VLS_OP_QB, 1'b1, 1'b0, 1'b0);
    refuse(VLS_OP_W_SAT, 1'b0, 1'b0, 1'b1);
    refuse(vls_op_t'(5'h03), 1'b1, 1'b1, 1'b1);
    $display("test refusals done");
    for (int n = 0; n < 400; n++) begin
      run_op(ops[$urandom_range(4)], $urandom, $urandom >> $urandom_range(31), 5'($urandom),
             1'($urandom_range(7) == 0), $urandom & ~VLS_OUFLAG_MASK);
    end
    i_issue = 1'b0;
    i_ctl_wr = 1'b0;
    $display("test random done");
    give_verdict();
  end

  // Watchdog against a hung run
  initial begin
    #(2_000_000);
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
